// [logic/njd_top.sv]
// node bring-up and network diagnostics with avalon register slave
`timescale 1ns/1ns
// Summary of operation
// - odd address write then read picks bus
// - zero node id: core stays asleep
// - join only after transmit enable bit 5
// - duplicate flag within 210 or 420 ms
// - compare node id with token destination, response
// - diagnostic read clears duplicate flag
// - joining network sets own reconfiguration flag
// - token timer expiry sets own reconfiguration
// - reconfiguration sets interrupting status bit
// - diagnostic read clears own reconfiguration
// - receive one sets activity flag
// - foreign token sets circulation seen flag
// - answered probe destination sets probe flag
// - successor id readable in own register
// - successor change sets successor flag
// - naks at limit set excess refusal
// - options bit chooses 128 or 4
// - wrapping counter, clear command rearms flag
// - disable command: available at next token
// - node id write makes two buffer writes
module njd_top #(
  parameter int DUP_SHORT_CYCLES = njd_pkg::DUP_SHORT_CYC,
  parameter int DUP_LONG_CYCLES  = njd_pkg::DUP_LONG_CYC,
  parameter int NETWORK_RECONFIG_FLAG_TIMEOUT    = 1024
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // serial receive pin
  input  wire logic              serial_receive_input_i,
  // link decoder events
  input  wire njd_pkg::njd_token_s token_i,
  input  wire logic              nak_i,
  input  wire logic              own_token_i,
  input  wire logic [7:0]        successor_i,
  input  wire logic              successor_valid_i,
  // core outputs
  output logic                   core_awake_o,
  output logic                   join_enable_o,
  output logic                   reconfig_start_o,
  output logic                   bus_mode_o,
  output logic                   network_reconfig_flag_irq_o,
  output logic                   excess_irq_o,
  output njd_pkg::njd_bufwr_s    buf_wr_o
);
  import njd_pkg::*;

  logic [7:0]  primary_options_reg_ff;
  logic [7:0]  node_identifier_reg_ff;
  logic [7:0]  config_ff;
  logic [7:0]  probe_id_reg_ff;
  logic [7:0]  successor_id_reg_ff;
  logic        own_reconfig_flag_ff, duplicate_id_flag_ff, receive_activity_flag_ff;
  logic        token_seen_ff, excess_refusal_flag_ff, probe_match_flag_ff, successor_changed_flag_ff;
  logic        network_reconfig_flag_ff, transmitter_available_ff, tx_cancel_ff;
  logic        bus_mode_ff, odd_written_ff, joined_ff;
  logic [7:0]  nak_cnt_ff;
  logic [31:0] dup_timer_ff, network_reconfig_flag_timer_ff;
  logic        rx_sync1_ff, rx_sync2_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  bufwr_step_ff;
  njd_bufwr_s  bufwr_ff;
  logic        in_sw_reset, awake, transmit_join_enable, short_refusal_limit;
  logic        wr_hit, rd_hit, diag_read, clr_cmd, dis_cmd, tok_v, dup_hit;
  logic [7:0]  nak_limit;
  logic [31:0] dup_limit;

  // decode helper for a register byte offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  // control decode
  assign in_sw_reset          = config_ff[CFG_SW_RST_BIT];
  assign awake                = (node_identifier_reg_ff != 8'h00) && !in_sw_reset;
  assign transmit_join_enable = config_ff[CFG_TX_EN_BIT] && awake;
  assign short_refusal_limit  = primary_options_reg_ff[OPT_SHORT_BIT];
  assign nak_limit            = short_refusal_limit ? NAK_LIMIT_SHORT : NAK_LIMIT_LONG;
  assign dup_limit            = (primary_options_reg_ff[OPT_ET_A_BIT] && primary_options_reg_ff[OPT_ET_B_BIT])
                                ? 32'(DUP_SHORT_CYCLES) : 32'(DUP_LONG_CYCLES);
  assign wr_hit    = avs_write_i && !ack_ff;
  assign rd_hit    = avs_read_i && !ack_ff;
  assign diag_read = rd_hit && hit(avs_address_i, OFF_DIAG);
  assign clr_cmd   = wr_hit && hit(avs_address_i, OFF_COMMAND) && avs_byteenable_i[0]
                     && avs_writedata_i[7:0] == CMD_CLEAR_FLAGS;
  assign dis_cmd   = wr_hit && hit(avs_address_i, OFF_COMMAND) && avs_byteenable_i[0]
                     && avs_writedata_i[7:0] == CMD_DISABLE_TX;
  assign tok_v     = token_i.valid && awake && !token_i.own;
  assign dup_hit   = tok_v && token_i.answered && token_i.dest == node_identifier_reg_ff
                     && !transmit_join_enable;

  // one wait cycle per access, answer on the second cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;

  // read data capture, unmapped reads return zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_hit) begin
      rdata_ff <= 32'h0000_0000;
      if (hit(avs_address_i, OFF_OPTIONS))  rdata_ff[7:0] <= primary_options_reg_ff;
      if (hit(avs_address_i, OFF_NODE_ID))  rdata_ff[7:0] <= node_identifier_reg_ff;
      if (hit(avs_address_i, OFF_CONFIG))   rdata_ff[7:0] <= config_ff;
      if (hit(avs_address_i, OFF_PROBE_ID)) rdata_ff[7:0] <= probe_id_reg_ff;
      if (hit(avs_address_i, OFF_SUCC_ID))  rdata_ff[7:0] <= successor_id_reg_ff;
      if (hit(avs_address_i, OFF_DIAG)) begin
        rdata_ff[DG_OWN_NETWORK_RECONFIG_FLAG] <= own_reconfig_flag_ff;
        rdata_ff[DG_DUP_ID]    <= duplicate_id_flag_ff;
        rdata_ff[DG_RX_ACT]    <= receive_activity_flag_ff;
        rdata_ff[DG_TOKEN]     <= token_seen_ff;
        rdata_ff[DG_EXCESS]    <= excess_refusal_flag_ff;
        rdata_ff[DG_PROBE]     <= probe_match_flag_ff;
        rdata_ff[DG_SUCC_CHG]  <= successor_changed_flag_ff;
      end
      if (hit(avs_address_i, OFF_STATUS)) begin
        rdata_ff[ST_TX_AVAIL] <= transmitter_available_ff;
        rdata_ff[ST_NETWORK_RECONFIG_FLAG]    <= network_reconfig_flag_ff;
      end
      if (hit(avs_address_i, OFF_BUS_PROBE)) rdata_ff[0] <= bus_mode_ff;
    end
  end
  assign avs_readdata_o = rdata_ff;

  // bus type: odd-byte write then odd-byte read on the probe word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      odd_written_ff <= 1'b0;
      bus_mode_ff    <= 1'b0;
    end else begin
      if (wr_hit && hit(avs_address_i, OFF_BUS_PROBE) && avs_byteenable_i[1]) odd_written_ff <= 1'b1;
      if (rd_hit && hit(avs_address_i, OFF_BUS_PROBE) && avs_byteenable_i[1] && odd_written_ff)
        bus_mode_ff <= 1'b1;
    end
  end

  // writable setup registers; software reset leaves options and config intact
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      primary_options_reg_ff <= 8'h00;
      node_identifier_reg_ff <= 8'h00;
      config_ff              <= 8'h00;
      probe_id_reg_ff        <= 8'h00;
    end else if (wr_hit && avs_byteenable_i[0]) begin
      if (hit(avs_address_i, OFF_OPTIONS))  primary_options_reg_ff <= avs_writedata_i[7:0];
      if (hit(avs_address_i, OFF_NODE_ID))  node_identifier_reg_ff <= avs_writedata_i[7:0];
      if (hit(avs_address_i, OFF_CONFIG))   config_ff              <= avs_writedata_i[7:0];
      if (hit(avs_address_i, OFF_PROBE_ID)) probe_id_reg_ff        <= avs_writedata_i[7:0];
    end
  end

  // two buffer writes after each node id write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bufwr_step_ff <= 2'h0;
      bufwr_ff      <= '0;
    end else begin
      bufwr_ff <= '0;
      if (bufwr_step_ff == 2'h1) begin
        bufwr_ff      <= '{valid: 1'b1, addr: BUF_ADDR_PAT, data: BUF_PATTERN};
        bufwr_step_ff <= 2'h2;
      end else if (bufwr_step_ff == 2'h2) begin
        bufwr_ff      <= '{valid: 1'b1, addr: BUF_ADDR_ID, data: node_identifier_reg_ff};
        bufwr_step_ff <= 2'h0;
      end
      if (wr_hit && avs_byteenable_i[0] && hit(avs_address_i, OFF_NODE_ID)) bufwr_step_ff <= 2'h1;
    end
  end
  assign buf_wr_o = bufwr_ff;

  // receive pin synchroniser
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sync1_ff <= 1'b0;
      rx_sync2_ff <= 1'b0;
    end else begin
      rx_sync1_ff <= serial_receive_input_i;
      rx_sync2_ff <= rx_sync1_ff;
    end
  end

  // diagnostic flags: events win over read clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      duplicate_id_flag_ff     <= 1'b0;
      receive_activity_flag_ff <= 1'b0;
      token_seen_ff            <= 1'b0;
      probe_match_flag_ff      <= 1'b0;
    end else begin
      if (diag_read) begin
        duplicate_id_flag_ff     <= 1'b0;
        receive_activity_flag_ff <= 1'b0;
        token_seen_ff            <= 1'b0;
        probe_match_flag_ff      <= 1'b0;
      end
      if (dup_hit && dup_timer_ff != 32'h0000_0000)
        duplicate_id_flag_ff <= 1'b1;
      if (rx_sync2_ff) receive_activity_flag_ff <= 1'b1;
      if (tok_v) token_seen_ff <= 1'b1;
      if (tok_v && token_i.answered && token_i.dest == probe_id_reg_ff) probe_match_flag_ff <= 1'b1;
    end
  end

  // duplicate observation window restarts on each node id write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dup_timer_ff <= 32'h0000_0000;
    end else if (wr_hit && hit(avs_address_i, OFF_NODE_ID)) begin
      dup_timer_ff <= dup_limit;
    end else if (dup_timer_ff != 32'h0000_0000) begin
      dup_timer_ff <= dup_timer_ff - 32'h0000_0001;
    end
  end

  // join detection and token reception timer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      joined_ff      <= 1'b0;
      network_reconfig_flag_timer_ff <= 32'h0000_0000;
    end else begin
      joined_ff <= transmit_join_enable;
      if (!transmit_join_enable || own_token_i || reconfig_start_o) network_reconfig_flag_timer_ff <= 32'h0000_0000;
      else network_reconfig_flag_timer_ff <= network_reconfig_flag_timer_ff + 32'h0000_0001;
    end
  end
  assign reconfig_start_o = transmit_join_enable &&
                            ((!joined_ff) || network_reconfig_flag_timer_ff == 32'(NETWORK_RECONFIG_FLAG_TIMEOUT));

  // reconfiguration flags
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      own_reconfig_flag_ff     <= 1'b0;
      network_reconfig_flag_ff <= 1'b0;
    end else begin
      if (diag_read) own_reconfig_flag_ff <= 1'b0;
      if (wr_hit && hit(avs_address_i, OFF_COMMAND) && avs_writedata_i[7:0] == CMD_CLEAR_NETWORK_RECONFIG_FLAG)
        network_reconfig_flag_ff <= 1'b0;
      if (reconfig_start_o) own_reconfig_flag_ff <= 1'b1;
      if (reconfig_start_o || (token_i.valid && awake && token_i.dest == 8'h00))
        network_reconfig_flag_ff <= 1'b1;
    end
  end

  // successor tracking
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      successor_id_reg_ff       <= 8'h00;
      successor_changed_flag_ff <= 1'b0;
    end else begin
      if (diag_read) successor_changed_flag_ff <= 1'b0;
      if (successor_valid_i && awake) begin
        successor_id_reg_ff <= successor_i;
        if (successor_i != successor_id_reg_ff) successor_changed_flag_ff <= 1'b1;
      end
    end
  end

  // refusal counter wraps at the selected limit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nak_cnt_ff             <= 8'h00;
      excess_refusal_flag_ff <= 1'b0;
    end else begin
      if (clr_cmd) excess_refusal_flag_ff <= 1'b0;
      if (nak_i && awake) begin
        if (nak_cnt_ff + 8'h01 >= nak_limit) begin
          nak_cnt_ff             <= 8'h00;
          excess_refusal_flag_ff <= 1'b1;
        end else begin
          nak_cnt_ff <= nak_cnt_ff + 8'h01;
        end
      end
    end
  end

  // transmitter available after cancel at next own token
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      transmitter_available_ff <= 1'b1;
      tx_cancel_ff             <= 1'b0;
    end else begin
      if (dis_cmd) tx_cancel_ff <= 1'b1;
      if (tx_cancel_ff && own_token_i) begin
        transmitter_available_ff <= 1'b1;
        tx_cancel_ff             <= 1'b0;
      end
      if (nak_i && awake) transmitter_available_ff <= 1'b0;
    end
  end

  // core outputs
  assign core_awake_o  = awake;
  assign join_enable_o = transmit_join_enable;
  assign bus_mode_o    = bus_mode_ff;
  assign network_reconfig_flag_irq_o   = network_reconfig_flag_ff;
  assign excess_irq_o  = excess_refusal_flag_ff;
endmodule : njd_top

// [logic/njd_pkg.sv]
// package of register offsets, fields and timing constants for the node join diagnostics block
package njd_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_OPTIONS   = 8'h00;
  localparam logic [7:0] OFF_NODE_ID   = 8'h04;
  localparam logic [7:0] OFF_CONFIG    = 8'h08;
  localparam logic [7:0] OFF_DIAG      = 8'h0C;
  localparam logic [7:0] OFF_PROBE_ID  = 8'h10;
  localparam logic [7:0] OFF_SUCC_ID   = 8'h14;
  localparam logic [7:0] OFF_COMMAND   = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  localparam logic [7:0] OFF_BUS_PROBE = 8'h20;
  // configuration register fields
  localparam int CFG_TX_EN_BIT  = 5;
  localparam int CFG_SW_RST_BIT = 7;
  // primary options fields
  localparam int OPT_ET_A_BIT   = 0;
  localparam int OPT_ET_B_BIT   = 1;
  localparam int OPT_SHORT_BIT  = 2;
  // diagnostic status bit positions
  localparam int DG_OWN_NETWORK_RECONFIG_FLAG   = 7;
  localparam int DG_DUP_ID      = 6;
  localparam int DG_RX_ACT      = 5;
  localparam int DG_TOKEN       = 4;
  localparam int DG_EXCESS      = 3;
  localparam int DG_PROBE       = 2;
  localparam int DG_SUCC_CHG    = 1;
  // main status bit positions
  localparam int ST_TX_AVAIL    = 0;
  localparam int ST_NETWORK_RECONFIG_FLAG       = 2;
  // command codes
  localparam logic [7:0] CMD_DISABLE_TX  = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1E;
  localparam logic [7:0] CMD_CLEAR_NETWORK_RECONFIG_FLAG = 8'h1F;
  // buffer pattern written at node id update
  localparam logic [7:0] BUF_PATTERN     = 8'hD1;
  localparam logic [10:0] BUF_ADDR_PAT   = 11'h000;
  localparam logic [10:0] BUF_ADDR_ID    = 11'h001;
  // refusal thresholds
  localparam logic [7:0] NAK_LIMIT_LONG  = 8'h80;
  localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;
  // duplicate detection limits
  localparam int CLK_MHZ        = 100;
  localparam int DUP_SHORT_MS   = 210;
  localparam int DUP_LONG_MS    = 420;
  localparam int DUP_SHORT_CYC  = DUP_SHORT_MS * 1000 * CLK_MHZ;
  localparam int DUP_LONG_CYC   = DUP_LONG_MS * 1000 * CLK_MHZ;

  // one observed token from the link decoder
  typedef struct packed {
    logic       valid;
    logic [7:0] dest;
    logic       own;
    logic       answered;
  } njd_token_s;

  // one buffer memory write request
  typedef struct packed {
    logic        valid;
    logic [10:0] addr;
    logic [7:0]  data;
  } njd_bufwr_s;
endpackage : njd_pkg

// [dv/njd_link_model.sv]
// network side model: observed tokens, refusals, successor reports and the receive line
`timescale 1ns/1ns
module njd_link_model
  import njd_pkg::*;
(
  // clock
  input  wire logic  clk_i,
  // events towards the block
  output njd_token_s token_o,
  output logic       nak_o,
  output logic       own_token_o,
  output logic [7:0] successor_o,
  output logic       successor_valid_o,
  output logic       serial_rx_o
);
  // quiet link at time zero
  initial begin
    token_o = '0;
    nak_o = 1'b0;
    own_token_o = 1'b0;
    successor_o = 8'h5A;
    successor_valid_o = 1'b0;
    serial_rx_o = 1'b0;
  end
  // one token; idle fields then carry the inverse so stale values never look like data
  task automatic token(input logic [7:0] d, input logic own, input logic ans);
    @(posedge clk_i);
    token_o <= {1'b1, d, own, ans};
    @(posedge clk_i);
    token_o <= {1'b0, ~d, ~own, ~ans};
  endtask : token
  // refusals one pulse each, one idle cycle apart or with random extra spacing
  task automatic naks(input int n, input bit slow);
    repeat (n) begin
      @(posedge clk_i);
      nak_o <= 1'b1;
      @(posedge clk_i);
      nak_o <= 1'b0;
      if (slow) repeat ($urandom_range(2, 0)) @(posedge clk_i);
    end
  endtask : naks
  // the token arrives at this node
  task automatic own_tok();
    @(posedge clk_i);
    own_token_o <= 1'b1;
    @(posedge clk_i);
    own_token_o <= 1'b0;
  endtask : own_tok
  // a successor report
  task automatic succ(input logic [7:0] s);
    @(posedge clk_i);
    successor_o <= s;
    successor_valid_o <= 1'b1;
    @(posedge clk_i);
    successor_o <= ~s;
    successor_valid_o <= 1'b0;
  endtask : succ
  // activity on the receive line for n cycles
  task automatic rx_act(input int n);
    @(posedge clk_i);
    serial_rx_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    serial_rx_o <= 1'b0;
  endtask : rx_act
endmodule : njd_link_model

// [dv/njd_top_sva.sv]
// assertion checker for the node join diagnostics block
`timescale 1ns/1ns
module njd_top_sva
  import njd_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // register bus and refusals
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        nak_i,
  // core outputs
  input wire logic        core_awake_o,
  input wire logic        join_enable_o,
  input wire logic        reconfig_start_o,
  input wire logic        bus_mode_o,
  input wire logic        network_reconfig_flag_irq_o,
  input wire logic        excess_irq_o,
  input wire njd_bufwr_s  buf_wr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] nid_seen_ff;
  // decoded bus events
  wire take_nid = avs_write_i && avs_waitrequest_o && avs_address_i == OFF_NODE_ID && avs_byteenable_i[0];
  wire clr_hit  = avs_write_i && avs_address_i == OFF_COMMAND && avs_writedata_i[7:0] == CMD_CLEAR_FLAGS;
  wire cfg_hit  = avs_write_i && (avs_address_i == OFF_CONFIG || avs_address_i == OFF_NODE_ID);
  wire probe_rd = avs_read_i && avs_address_i == OFF_BUS_PROBE;
  // remember the node id being written
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) nid_seen_ff <= 8'h00;
    else if (take_nid) nid_seen_ff <= avs_writedata_i[7:0];
  end
  sequence pat_wr_s; buf_wr_o.valid && buf_wr_o.addr == BUF_ADDR_PAT && buf_wr_o.data == BUF_PATTERN; endsequence
  sequence id_wr_s; buf_wr_o.valid && buf_wr_o.addr == BUF_ADDR_ID && buf_wr_o.data == nid_seen_ff; endsequence
  sleep_quiet_a: assert property (!core_awake_o |-> !join_enable_o && !reconfig_start_o)
    else $error("activity while node id is zero");
  join_gate_a: assert property ($rose(join_enable_o) |-> $past(cfg_hit) || $past(cfg_hit, 2))
    else $error("join without configuration write");
  join_network_reconfig_flag_a: assert property ($rose(join_enable_o) |-> reconfig_start_o)
    else $error("join without reconfiguration");
  network_reconfig_flag_irq_a: assert property (reconfig_start_o |-> ##[0:2] network_reconfig_flag_irq_o)
    else $error("reconfiguration did not raise status");
  node_buf_a: assert property (take_nid |-> ##[1:3] pat_wr_s ##1 id_wr_s)
    else $error("node id buffer writes wrong");
  excess_hold_a: assert property ($fell(excess_irq_o) |-> $past(clr_hit) || $past(clr_hit, 2))
    else $error("refusal flag dropped without clear");
  excess_cause_a: assert property ($rose(excess_irq_o) |-> $past(nak_i) || $past(nak_i, 2))
    else $error("refusal flag set without refusal");
  bus_mode_a: assert property ($changed(bus_mode_o) |-> $past(probe_rd) || $past(probe_rd, 2))
    else $error("bus mode changed without odd read");
endmodule : njd_top_sva
bind njd_top njd_top_sva i_sva (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_waitrequest_o, .nak_i, .core_awake_o, .join_enable_o, .reconfig_start_o, .bus_mode_o,
  .network_reconfig_flag_irq_o, .excess_irq_o, .buf_wr_o);

// [dv/node_join_diagnostics_bench.sv]
// self-checking bench for the node join diagnostics block
`timescale 1ns/1ns
module node_join_diagnostics_bench;
  import njd_pkg::*;
  localparam int DUP_L = 100;
  localparam int RTO   = 64;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic [7:0]  succ;
  logic        avs_waitrequest_o, nak, own_tok, succ_v, serial_rx, core_awake_o, join_enable_o;
  logic        reconfig_start_o, bus_mode_o, network_reconfig_flag_irq_o, excess_irq_o;
  njd_token_s  tok;
  njd_bufwr_s  buf_wr_o;
  int          err_total = 0;
  int          cmp_count = 0;
  always #5 clk_i = ~clk_i;
  njd_link_model i_link (.clk_i(clk_i), .token_o(tok), .nak_o(nak), .own_token_o(own_tok), .successor_o(succ),
    .successor_valid_o(succ_v), .serial_rx_o(serial_rx));
  njd_top #(.DUP_SHORT_CYCLES(50), .DUP_LONG_CYCLES(DUP_L), .NETWORK_RECONFIG_FLAG_TIMEOUT(RTO)) i_dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .serial_receive_input_i(serial_rx), .token_i(tok), .nak_i(nak),
    .own_token_i(own_tok), .successor_i(succ), .successor_valid_i(succ_v), .core_awake_o(core_awake_o),
    .join_enable_o(join_enable_o), .reconfig_start_o(reconfig_start_o), .bus_mode_o(bus_mode_o),
    .network_reconfig_flag_irq_o(network_reconfig_flag_irq_o), .excess_irq_o(excess_irq_o), .buf_wr_o(buf_wr_o));
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // threshold of refusals for the short or long setting
  function automatic int nak_lim(input bit short_sel);
    return short_sel ? int'(NAK_LIMIT_SHORT) : int'(NAK_LIMIT_LONG);
  endfunction : nak_lim
  // one bus cycle held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        err_total++;
        final_report();
      end
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  // byte write to a register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, 4'h1, q);
  endtask : wr
  // masked register read compared against expectation
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h1, q);
    check(q & m, exp);
  endtask : rd_chk
  // let n edges pass, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : tick
  // overall hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    logic [7:0]  node_identifier_reg, pid, sv;
    logic [31:0] q;
    q = $urandom(32'hAE6A25E9);
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    tick(1);
    rd_chk(OFF_STATUS, 32'h1, 32'hFFFFFFFF);
    rd_chk(OFF_DIAG, 32'h0, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, OFF_BUS_PROBE, 32'h100, 4'h2, q);
    tick(1);
    check(bus_mode_o, 32'h0);
    bus(1'b0, OFF_BUS_PROBE, 32'h0, 4'h2, q);
    tick(1);
    check(bus_mode_o, 32'h1);
    wr(OFF_CONFIG, 8'h20);
    i_link.token(8'h01, 1'b0, 1'b1);
    tick(2);
    check({core_awake_o, join_enable_o}, 32'h0);
    wr(OFF_CONFIG, 8'h00);
    wr(OFF_OPTIONS, 8'h00);
    node_identifier_reg = 8'($urandom_range(200, 1));
    pid = node_identifier_reg + 8'h20;
    wr(OFF_NODE_ID, node_identifier_reg);
    tick(3);
    check({core_awake_o, join_enable_o}, 32'h2);
    bus(1'b0, OFF_DIAG, 32'h0, 4'h1, q);
    i_link.rx_act(3);
    i_link.token(node_identifier_reg ^ 8'h40, 1'b1, 1'b1);
    tick(4);
    rd_chk(OFF_DIAG, 32'h20, 32'hFF);
    i_link.token(node_identifier_reg, 1'b0, 1'b0);
    tick(2);
    rd_chk(OFF_DIAG, 32'h10, 32'hFF);
    i_link.token(node_identifier_reg, 1'b0, 1'b1);
    tick(DUP_L);
    rd_chk(OFF_DIAG, 32'h50, 32'hFF);
    rd_chk(OFF_DIAG, 32'h0, 32'hFF);
    wr(OFF_NODE_ID, node_identifier_reg + 8'h01);
    i_link.token(node_identifier_reg, 1'b0, 1'b1);
    tick(DUP_L);
    rd_chk(OFF_DIAG, 32'h0, 32'h40);
    wr(OFF_PROBE_ID, pid);
    i_link.token(pid, 1'b0, 1'b1);
    tick(2);
    rd_chk(OFF_DIAG, 32'h14, 32'hFF);
    sv = 8'($urandom_range(255, 1));
    i_link.succ(sv);
    tick(2);
    rd_chk(OFF_SUCC_ID, {24'h0, sv}, 32'hFF);
    rd_chk(OFF_DIAG, 32'h02, 32'hFF);
    wr(OFF_CONFIG, 8'h20);
    tick(1);
    check(join_enable_o, 32'h1);
    rd_chk(OFF_DIAG, 32'h80, 32'h80);
    rd_chk(OFF_STATUS, 32'h4, 32'h4);
    check(network_reconfig_flag_irq_o, 32'h1);
    wr(OFF_PROBE_ID, pid + 8'h01);
    i_link.token(pid + 8'h01, 1'b0, 1'b1);
    tick(2);
    rd_chk(OFF_DIAG, 32'h04, 32'h04);
    tick(RTO + 20);
    rd_chk(OFF_DIAG, 32'h80, 32'h80);
    rd_chk(OFF_DIAG, 32'h00, 32'h80);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_OPTIONS, s[0] ? 8'h04 : 8'h00);
      wr(OFF_COMMAND, CMD_CLEAR_FLAGS);
      for (int k = 0; k < 2; k++) begin
        i_link.naks(nak_lim(s[0]) - 1, !s[0]);
        tick(3);
        check(excess_irq_o, 32'h0);
        i_link.naks(1, 1'b0);
        tick(3);
        check(excess_irq_o, 32'h1);
        rd_chk(OFF_DIAG, 32'h08, 32'h08);
        wr(OFF_COMMAND, CMD_CLEAR_FLAGS);
        tick(1);
        check(excess_irq_o, 32'h0);
      end
    end
    wr(OFF_COMMAND, CMD_DISABLE_TX);
    rd_chk(OFF_STATUS, 32'h0, 32'h1);
    i_link.own_tok();
    tick(2);
    rd_chk(OFF_STATUS, 32'h1, 32'h1);
    final_report();
  end
endmodule : node_join_diagnostics_bench
